// *** rtl/adcsp_params.svh ***
/*
  Timing and coding constants for the start/status/result port of the converter.
  Assumes a 200 MHz ref_clk; included by the core module.
*/
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH

`define ADCSP_CLK_PERIOD_PS 5000
`define ADCSP_CONV_TIME_NS 300
`define ADCSP_CONV_CYCLES ((`ADCSP_CONV_TIME_NS * 1000) / `ADCSP_CLK_PERIOD_PS)
`define ADCSP_RES_BITS 14
`define ADCSP_CODE_ZERO 14'h0000
`define ADCSP_CODE_MID 14'h2000
`define ADCSP_CODE_FULL 14'h3fff
`define ADCSP_RAW_MIN 15'sh6000
`define ADCSP_RAW_MAX 15'sh1fff

`endif

// *** rtl/adcsp_pkg.sv ***
/*
  Types for the converter digital port.
  Assumes adcsp_params.svh is on the include path.
*/
package adcsp_pkg;
  typedef enum logic [1:0] {
    ADCSP_IDLE = 2'b01,
    ADCSP_CONV = 2'b10
  } adcsp_state_t;
endpackage

// *** rtl/adcsp_core.sv ***
/*
  Digital side of a 14-bit sampling converter: start edge detect, conversion timer,
  in-progress status and offset binary result register.
  Assumes the analog front end delivers a signed two's complement sample in LSB steps,
  already rounded so that code edges fall half a step from each code centre.
  Assumes start_conv comes straight from a pin and may change at any time against ref_clk;
  it passes three flip-flops, which adds three cycles of latency to every start.
  Assumes analog_sample is settled at the clock edge that takes the start edge;
  the sample is frozen there, so later movement of the input does not reach the result.
  A start pulse shorter than two ref_clk periods may be missed, and start must stay
  low for two periods before a new rising edge counts.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcsp_params.svh"

module adcsp_core
  import adcsp_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCSP_CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start_conv,
  input wire logic signed [14:0] analog_sample,
  output logic conv_busy,
  output logic conv_invalid,
  output logic [13:0] result
);

  localparam int CW = $clog2(CONV_CYCLES + 1);

  // Clip bounds of the front-end sample and the timer load value.
  localparam logic signed [14:0] RAW_LO = `ADCSP_RAW_MIN;
  localparam logic signed [14:0] RAW_HI = `ADCSP_RAW_MAX;
  localparam logic [CW-1:0] CNT_LOAD = CW'(CONV_CYCLES - 1);

  // Start pin synchroniser.
  logic [2:0] start_sync_q;
  logic [2:0] start_sync_d;
  logic start_lvl_q;
  logic start_lvl_d;
  logic start_edge;

  // Conversion sequencer.
  adcsp_state_t state_q;
  adcsp_state_t state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic signed [14:0] sample_q;
  logic signed [14:0] sample_d;
  logic dirty_q;
  logic dirty_d;
  logic cnt_done;
  logic finish;

  // Result register.
  logic signed [14:0] clipped;
  logic [13:0] code;
  logic [13:0] result_q;
  logic [13:0] result_d;
  logic invalid_q;
  logic invalid_d;

  // Start is a pin; a level change counts only once stages two and three agree,
  // so a single metastable or glitching sample never makes an edge on its own.
  always_comb begin
    start_sync_d = {start_sync_q[1:0], start_conv};
    start_lvl_d = start_lvl_q;
    if (start_sync_q[1] == start_sync_q[2]) begin
      start_lvl_d = start_sync_q[2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      start_sync_q <= 3'h0;
      start_lvl_q <= 1'b0;
    end else begin
      start_sync_q <= start_sync_d;
      start_lvl_q <= start_lvl_d;
    end
  end

  // The level resets low, the idle level of the pin, so no false edge follows reset.
  // A pulse held high for two periods or longer makes exactly one edge.
  assign start_edge = start_lvl_d & ~start_lvl_q;

  // A fresh start edge beats completion in the same cycle, so an interrupted
  // conversion never reaches the outputs.
  assign cnt_done = (cnt_q == '0);
  assign finish = (state_q == ADCSP_CONV) && !start_edge && cnt_done;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sample_d = sample_q;
    dirty_d = dirty_q;
    unique case (state_q)
      ADCSP_IDLE: begin
        if (start_edge) begin
          // The start edge is the sampling instant.
          sample_d = analog_sample;
          cnt_d = CNT_LOAD;
          dirty_d = 1'b0;
          state_d = ADCSP_CONV;
        end
      end
      ADCSP_CONV: begin
        if (start_edge) begin
          // Restart from the new sample; the flag marks this result as untrustworthy.
          sample_d = analog_sample;
          cnt_d = CNT_LOAD;
          dirty_d = 1'b1;
        end else if (cnt_done) begin
          state_d = ADCSP_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        // Two state bits allow codes the encoding never uses; an upset lands here
        // and returns to idle rather than hanging with status in an unknown state.
        state_d = ADCSP_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ADCSP_IDLE;
      cnt_q <= '0;
      sample_q <= 15'h0000;
      dirty_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sample_q <= sample_d;
      dirty_q <= dirty_d;
    end
  end

  // Samples beyond either full scale saturate at the end codes instead of wrapping
  // around to the opposite end of the range.
  always_comb begin
    clipped = sample_q;
    if (sample_q > RAW_HI) begin
      clipped = RAW_HI;
    end else if (sample_q < RAW_LO) begin
      clipped = RAW_LO;
    end
  end

  // Offset binary: the clipped sample fits 14 bits of two's complement, so only
  // the sign bit is inverted and every lower bit passes straight through.
  for (genvar b = 0; b < 14; b++) begin : g_code
    if (b == 13) begin : g_msb
      assign code[b] = ~clipped[b];
    end else begin : g_low
      assign code[b] = clipped[b];
    end
  end

  // Result and flag change together, only at completion, and then stand.
  always_comb begin
    result_d = result_q;
    invalid_d = invalid_q;
    if (finish) begin
      result_d = code;
      invalid_d = dirty_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_q <= `ADCSP_CODE_ZERO;
      invalid_q <= 1'b0;
    end else begin
      result_q <= result_d;
      invalid_q <= invalid_d;
    end
  end

  // Status comes straight from the state register, so it falls in the same edge
  // that loads the result and the controller may latch data on its falling edge.
  assign conv_busy = (state_q == ADCSP_CONV);
  assign conv_invalid = invalid_q;
  assign result = result_q;

endmodule
`default_nettype wire

// *** testbench/adcsp_ctl.sv ***
/* Controller model that fires 20 ns start pulses, or holds start high while a wide pulse is asked for.
   Assumes a 200 MHz ref_clk and requests that change just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module adcsp_ctl(
  input wire logic ref_clk,
  input wire logic fire,
  input wire logic wide,
  output logic start_conv
);
  int hi_q = 0;
  logic wide_q = 1'b0;
  always @(posedge ref_clk) hi_q <= (fire && hi_q == 0) ? 4 : (hi_q > 0 ? hi_q - 1 : 0);
  always @(posedge ref_clk) wide_q <= wide;
  assign start_conv = (hi_q != 0) || wide_q;
endmodule
`default_nettype wire

// *** testbench/adcsp_chk.sv ***
/* Port checker for the converter core.
   Assumes the bind below; analog_sample is held through a conversion. */
`timescale 1ns/1ps
`default_nettype none
module adcsp_chk(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start_conv,
  input wire logic signed [14:0] analog_sample,
  input wire logic conv_busy,
  input wire logic conv_invalid,
  input wire logic [13:0] result
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_done; $fell(conv_busy); endsequence
  sequence s_begin; $rose(conv_busy); endsequence
  a_busy_rise: assert property ($rose(start_conv) |-> ##[1:4] conv_busy) else $error("busy late");
  a_out_hold: assert property (!$fell(conv_busy) |-> $stable(result) && $stable(conv_invalid))
    else $error("output moved");
  a_restart_flag: assert property ($rose(start_conv) && conv_busy ##1 conv_busy[*3] |->
    ##[1:90] s_done ##0 conv_invalid) else $error("no flag");
  a_code_map: assert property (s_done ##0 !conv_invalid |->
    result == ((analog_sample > 15'sd8191) ? 14'h3fff : (analog_sample < -15'sd8192) ? 14'h0000 :
    14'(analog_sample + 15'sd8192))) else $error("bad code");
  a_start_cause: assert property (s_begin |-> $past(start_conv, 3)) else $error("busy without start");
endmodule
bind adcsp_core adcsp_chk u_chk(.ref_clk(ref_clk), .rstn(rstn), .start_conv(start_conv),
  .analog_sample(analog_sample), .conv_busy(conv_busy), .conv_invalid(conv_invalid), .result(result));
`default_nettype wire

// *** testbench/testbench.sv ***
/* Self-checking bench for adcsp_core.
   Assumes design, checker and controller model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("FAIL %0t mismatch", $time); end end
module testbench;
  logic ref_clk = 0, rstn = 0, fire = 0, wide = 0, start_conv, conv_busy, conv_invalid;
  logic signed [14:0] analog_sample = 0;
  logic [13:0] result;
  int err_total = 0, tests_run = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  adcsp_ctl ctl(.ref_clk(ref_clk), .fire(fire), .wide(wide), .start_conv(start_conv));
  adcsp_core #(.CONV_CYCLES(16)) uut(.ref_clk(ref_clk), .rstn(rstn), .start_conv(start_conv),
    .analog_sample(analog_sample), .conv_busy(conv_busy), .conv_invalid(conv_invalid), .result(result));
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Six low cycles after each conversion keep the 30 ns gap between pulses.
  task automatic run(input logic signed [14:0] s);
    int n = 0;
    analog_sample = s;
    fire = 1;
    @(posedge ref_clk) #1 fire = 0;
    while (conv_busy !== 1'b1 && n < 9) begin @(posedge ref_clk) #1 n++; end
    while (conv_busy !== 1'b0 && n < 40) begin @(posedge ref_clk) #1 n++; end
    `CHK(n < 40, 1'b1)
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic t_wide;
    analog_sample = 15'sd2000;
    wide = 1;
    repeat (70) @(posedge ref_clk);
    #1 `CHK(conv_busy, 1'b0)
    `CHK(result, 14'h27d0)
    `CHK(conv_invalid, 1'b0)
    wide = 0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  // Back-to-back conversions around the two calibration points make the bottom bit flicker.
  task automatic t_train;
    logic signed [14:0] s[4] = '{0, 1, 8190, 8191};
    logic [13:0] e[4] = '{14'h2000, 14'h2001, 14'h3ffe, 14'h3fff};
    for (int i = 0; i < 8; i++) begin
      run(s[(i % 2) + 2 * (i / 4)]);
      `CHK(result, e[(i % 2) + 2 * (i / 4)])
    end
  endtask
  task automatic t_codes;
    logic signed [14:0] s[6] = '{0, 1, -8192, 8191, -4096, 9000};
    logic [13:0] e[6] = '{14'h2000, 14'h2001, 14'h0000, 14'h3fff, 14'h1000, 14'h3fff};
    for (int i = 0; i < 6; i++) begin
      run(s[i]);
      `CHK(result, e[i])
      `CHK(conv_invalid, 1'b0)
    end
  endtask
  task automatic t_restart;
    analog_sample = 15'sd100;
    fire = 1;
    @(posedge ref_clk) #1 fire = 0;
    repeat (10) @(posedge ref_clk);
    #1 `CHK(result, 14'h0000)
    run(-15'sd100);
    `CHK(conv_invalid, 1'b1)
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1;
    repeat (2) @(posedge ref_clk);
    #1 t_restart;
    t_codes;
    t_wide;
    t_train;
    tally_and_finish;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish;
    end
  end
endmodule
`default_nettype wire
